// *** common/tplc_pkg.sv ***
// Purpose: Shared constants and types for the twisted-pair port link controller.
// Assumes: aclk at 250 MHz, registers reached over AXI4-Lite.
// Notes: Link pulse timing counts are defaults for top-level parameters.
// Summary of operation
// - Port leaves reset negotiating; control register shows and changes the mode.
// - Negotiation sends and receives bursts carrying a sixteen-bit capability word.
// - Sent word comes from advertisement register; received word stored as partner.
// - Advertisement register accepts writes only at bits 5, 7 and 13.
// - Only 100 and 10 half-duplex are ever advertised, never full duplex.
// - Without negotiation, idle symbols or link pulses pick the speed and status.
// - Forced 100 or 10 mode takes effect only at a repeater reset; every link is half-duplex.
// - Repeater reset keeps register configuration and never re-reads strap pins.
// - A linked port is attached to the repeater of its resolved speed.
// - On link loss the port detaches and returns to negotiation, or to waiting for the line in a forced mode.
// - Each MII expansion port takes its speed from a strap level.
// - MII ports keep all statistics except isolation, partition and symbol errors.
// - A disabled port keeps its transmit pair outputs undriven.
// - 100 mode sends a continuous scrambled stream with idle symbols between frames.
// - 10 mode sends Manchester data only while a frame is transmitted.
// - Idle 10 mode sends a pulse every 16 ms, expects pulses 10 to 20 ms apart.
// - In forced 10 mode, missing pulses switch the transmitter off unless pulses are ignored.
// - 10 mode detects a reversed receive pair and corrects it.
// - MII ports have no MDIO access; management uses the serial interface.
// - Active-low reset clears circuits, state machines and counters.
`default_nettype none
package tplc_pkg;
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned LP_PERIOD_MS = 16;
  localparam int unsigned LP_MIN_MS = 10;
  localparam int unsigned LP_MAX_MS = 20;
  localparam int unsigned LP_PERIOD_CYC = LP_PERIOD_MS * CLK_KHZ;
  localparam int unsigned LP_MIN_CYC = LP_MIN_MS * CLK_KHZ;
  localparam int unsigned LP_MAX_CYC = LP_MAX_MS * CLK_KHZ;
  localparam int TMR_W = 23;
  localparam int STRAP_WAIT = 4;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ADV = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PARTNER = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_RPT_RESET = 8'h90;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_IGN_BIT = 3;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam logic [1:0] MODE_AN = 2'h0;
  localparam logic [1:0] MODE_F100 = 2'h1;
  localparam logic [1:0] MODE_F10 = 2'h2;
  localparam int RPT_RESET_BIT = 0;

  localparam int ADV_10HD_BIT = 5;
  localparam int ADV_100HD_BIT = 7;
  localparam logic [15:0] ADV_RESET = 16'h00a1;
  localparam logic [15:0] ADV_WMASK = 16'h20a0;

  localparam int ST_LINK_BIT = 0;
  localparam int ST_SPD100_BIT = 1;
  localparam int ST_ATT10_BIT = 2;
  localparam int ST_ATT100_BIT = 3;
  localparam int ST_NOMATCH_BIT = 4;
  localparam int ST_POLINV_BIT = 5;
  localparam int ST_MII0_BIT = 6;
  localparam int ST_MII1_BIT = 7;
  localparam int ST_EARLY_BIT = 8;
  localparam int ST_TP_ERRSTAT_BIT = 9;
  localparam int ST_MII_ERRSTAT_BIT = 10;

  typedef enum logic [2:0] {
    ST_OFF, ST_AN, ST_WAIT, ST_LINK10, ST_LINK100, ST_NOMATCH
  } tplc_state_t;
endpackage
`default_nettype wire

// *** rtl/tplc_sync.sv ***
// Purpose: Three-stage input synchroniser for pin-level signals.
// Assumes: Inputs are levels that stay put for several clocks.
// Notes: A bit moves to the output once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module tplc_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] q;
  } tplc_sync_t;

  tplc_sync_t s;
  tplc_sync_t next_s;

  always_comb begin
    next_s = s;
    next_s.ff1 = din;
    next_s.ff2 = s.ff1;
    next_s.ff3 = s.ff2;
    // Stage one is only ever read by stage two.
    next_s.q = (s.ff2 & s.ff3) | (s.q & (s.ff2 | s.ff3));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.q;
endmodule
`default_nettype wire

// *** rtl/tplc_port.sv ***
// Purpose: Link setup and maintenance for one twisted-pair repeater port.
// Assumes: Pin inputs are asynchronous levels; tx_frame_active is on aclk.
// Notes: Speed changes take effect only through the repeater reset register.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tplc_port
  import tplc_pkg::*;
#(
  parameter logic [TMR_W-1:0] LP_PERIOD = TMR_W'(LP_PERIOD_CYC),
  parameter logic [TMR_W-1:0] LP_MIN = TMR_W'(LP_MIN_CYC),
  parameter logic [TMR_W-1:0] LP_MAX = TMR_W'(LP_MAX_CYC)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tp_receive_pair_link_pulse,
  input wire logic tp_receive_pair_idle,
  input wire logic tp_receive_pair_pol_rev,
  input wire logic tp_receive_pair_flp_stb,
  input wire logic [15:0] tp_receive_pair_flp_word,
  input wire logic strap_mii0_100,
  input wire logic strap_mii1_100,
  input wire logic tx_frame_active,
  output logic [15:0] tx_flp_word,
  output logic tx_flp_burst,
  output logic tx_link_pulse,
  output logic tx_stream_100,
  output logic tx_manchester_en,
  output logic tp_transmit_pair_oe,
  output logic rx_polarity_invert,
  output logic attach_10,
  output logic attach_100,
  output logic mii0_speed_100,
  output logic mii1_speed_100
);
  localparam int SYNC_W = 22;

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_ok;
    logic [ADDR_W-1:0] aw_addr;
    logic w_ok;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic ctrl_en;
    logic [1:0] ctrl_mode;
    logic ctrl_ign;
    logic [15:0] adv;
    logic [15:0] partner;
    tplc_state_t state;
    logic [1:0] mode_act;
    logic [TMR_W-1:0] tx_cnt;
    logic [TMR_W-1:0] rx_cnt;
    logic lp_seen;
    logic lp_early;
    logic [2:0] strap_cnt;
    logic mii0_100;
    logic mii1_100;
    logic lp_d;
    logic stb_d;
    logic flp_burst;
    logic link_pulse;
    logic stream_100;
    logic manch;
    logic tx_oe;
    logic pol_inv;
    logic att10;
    logic att100;
  } tplc_regs_t;

  localparam tplc_regs_t REGS_RESET = '{
    ctrl_en: CTRL_EN_RESET,
    adv: ADV_RESET,
    mode_act: MODE_AN,
    state: ST_OFF,
    default: '0
  };

  tplc_regs_t s;
  tplc_regs_t next_s;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [SYNC_W-1:0] sy;
  logic sy_lp;
  logic sy_idle;
  logic sy_pol;
  logic sy_stb;
  logic sy_s0;
  logic sy_s1;
  logic [15:0] sy_word;

  tplc_sync #(
    .W(SYNC_W)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({strap_mii1_100, strap_mii0_100, tp_receive_pair_flp_stb,
          tp_receive_pair_pol_rev, tp_receive_pair_idle,
          tp_receive_pair_link_pulse, tp_receive_pair_flp_word}),
    .dout(sy)
  );

  assign sy_word = sy[15:0];
  assign sy_lp = sy[16];
  assign sy_idle = sy[17];
  assign sy_pol = sy[18];
  assign sy_stb = sy[19];
  assign sy_s0 = sy[20];
  assign sy_s1 = sy[21];

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  logic lp_edge;
  logic stb_edge;
  logic tick;
  logic in10;
  logic [15:0] common;
  logic [15:0] wr16;
  tplc_state_t drop;

  always_comb begin
    next_s = s;
    lp_edge = sy_lp & ~s.lp_d;
    stb_edge = sy_stb & ~s.stb_d;
    tick = (s.tx_cnt == LP_PERIOD - 1'b1);
    common = s.adv & sy_word;
    wr16 = {s.w_strb[1] ? s.w_data[15:8] : s.adv[15:8],
            s.w_strb[0] ? s.w_data[7:0] : s.adv[7:0]};
    drop = (s.mode_act == MODE_AN) ? ST_AN : ST_WAIT;
    next_s.lp_d = sy_lp;
    next_s.stb_d = sy_stb;
    next_s.flp_burst = 1'b0;
    next_s.link_pulse = 1'b0;

    // Straps are caught once the synchroniser has settled after reset.
    if (s.strap_cnt != 3'(STRAP_WAIT + 1)) begin
      next_s.strap_cnt = s.strap_cnt + 1'b1;
    end else begin
      next_s.strap_cnt = s.strap_cnt;
    end
    if (s.strap_cnt == 3'(STRAP_WAIT)) begin
      next_s.mii0_100 = sy_s0;
      next_s.mii1_100 = sy_s1;
    end

    // Free-running period for bursts and outgoing link pulses.
    next_s.tx_cnt = tick ? '0 : s.tx_cnt + 1'b1;

    // Received link pulse spacing.
    if (s.rx_cnt != LP_MAX) begin
      next_s.rx_cnt = s.rx_cnt + 1'b1;
    end else begin
      next_s.lp_seen = 1'b0;
    end
    if (lp_edge) begin
      if (s.lp_seen && (s.rx_cnt < LP_MIN)) begin
        next_s.lp_early = 1'b1;
      end
      next_s.rx_cnt = '0;
      next_s.lp_seen = 1'b1;
    end

    // ------------------------------------------------------------------
    // Link state machine
    // ------------------------------------------------------------------
    if (!s.ctrl_en) begin
      next_s.state = ST_OFF;
    end else begin
      case (s.state)
        ST_OFF: begin
          next_s.state = drop;
        end
        ST_AN: begin
          if (tick) begin
            next_s.flp_burst = 1'b1;
          end
          if (stb_edge) begin
            next_s.partner = sy_word;
            if (common[ADV_100HD_BIT]) begin
              next_s.state = ST_LINK100;
            end else if (common[ADV_10HD_BIT]) begin
              next_s.state = ST_LINK10;
            end else begin
              next_s.state = ST_NOMATCH;
            end
          end else if (sy_idle) begin
            next_s.state = ST_LINK100;
          end else if (lp_edge) begin
            next_s.state = ST_LINK10;
          end
        end
        ST_WAIT: begin
          if (s.mode_act == MODE_F100) begin
            if (sy_idle) begin
              next_s.state = ST_LINK100;
            end
          end else if (lp_edge || s.ctrl_ign) begin
            next_s.state = ST_LINK10;
          end
        end
        ST_LINK100: begin
          if (!sy_idle) begin
            next_s.state = drop;
          end
        end
        ST_LINK10: begin
          if (!s.lp_seen && !s.ctrl_ign) begin
            next_s.state = drop;
          end
        end
        ST_NOMATCH: begin
          next_s.state = ST_NOMATCH;
        end
        default: begin
          next_s.state = ST_OFF;
        end
      endcase
    end
    if ((next_s.state == ST_LINK10) && (s.state != ST_LINK10)) begin
      next_s.rx_cnt = '0;
      next_s.lp_seen = 1'b1;
    end

    // ------------------------------------------------------------------
    // Register write channel
    // ------------------------------------------------------------------
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_ok = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_ok = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.aw_ok && s.w_ok) begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case (s.aw_addr)
        ADDR_CTRL: begin
          if (s.w_strb[0]) begin
            next_s.ctrl_en = s.w_data[CTRL_EN_BIT];
            next_s.ctrl_mode = s.w_data[CTRL_MODE_LSB +: 2];
            next_s.ctrl_ign = s.w_data[CTRL_IGN_BIT];
          end
        end
        ADDR_ADV: begin
          next_s.adv = (s.adv & ~ADV_WMASK) | (wr16 & ADV_WMASK);
        end
        ADDR_PARTNER, ADDR_STAT: begin
          next_s.bresp = RESP_OKAY;
        end
        ADDR_RPT_RESET: begin
          if (s.w_strb[0] && s.w_data[RPT_RESET_BIT]) begin
            // Loads the new speed; straps and registers stay untouched.
            next_s.mode_act = s.ctrl_mode;
            next_s.state = ST_OFF;
            next_s.tx_cnt = '0;
            next_s.rx_cnt = '0;
            next_s.lp_seen = 1'b0;
            next_s.lp_early = lp_edge && s.lp_seen && (s.rx_cnt < LP_MIN);
          end
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end
    next_s.awready = !next_s.aw_ok && !next_s.bvalid;
    next_s.wready = !next_s.w_ok && !next_s.bvalid;

    // ------------------------------------------------------------------
    // Register read channel
    // ------------------------------------------------------------------
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = '0;
      case (s_axi_araddr)
        ADDR_CTRL: begin
          next_s.rdata[CTRL_EN_BIT] = s.ctrl_en;
          next_s.rdata[CTRL_MODE_LSB +: 2] = s.ctrl_mode;
          next_s.rdata[CTRL_IGN_BIT] = s.ctrl_ign;
        end
        ADDR_ADV: begin
          next_s.rdata[15:0] = s.adv;
        end
        ADDR_PARTNER: begin
          next_s.rdata[15:0] = s.partner;
        end
        ADDR_STAT: begin
          next_s.rdata[ST_LINK_BIT] = s.att10 | s.att100;
          next_s.rdata[ST_SPD100_BIT] = s.att100;
          next_s.rdata[ST_ATT10_BIT] = s.att10;
          next_s.rdata[ST_ATT100_BIT] = s.att100;
          next_s.rdata[ST_NOMATCH_BIT] = (s.state == ST_NOMATCH);
          next_s.rdata[ST_POLINV_BIT] = s.pol_inv;
          next_s.rdata[ST_MII0_BIT] = s.mii0_100;
          next_s.rdata[ST_MII1_BIT] = s.mii1_100;
          next_s.rdata[ST_EARLY_BIT] = s.lp_early;
          // Error-class counters run for this port, never for MII ports.
          next_s.rdata[ST_TP_ERRSTAT_BIT] = 1'b1;
          next_s.rdata[ST_MII_ERRSTAT_BIT] = 1'b0;
        end
        ADDR_RPT_RESET: begin
          next_s.rdata = '0;
        end
        default: begin
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;

    // ------------------------------------------------------------------
    // Line-side outputs
    // ------------------------------------------------------------------
    in10 = (next_s.state == ST_LINK10) ||
           ((next_s.state == ST_WAIT) && (next_s.mode_act == MODE_F10));
    next_s.att10 = (next_s.state == ST_LINK10);
    next_s.att100 = (next_s.state == ST_LINK100);
    next_s.stream_100 = (next_s.state == ST_LINK100) ||
                        ((next_s.state == ST_WAIT) && (next_s.mode_act == MODE_F100));
    next_s.manch = in10 && tx_frame_active;
    if (in10 && tick && !tx_frame_active) begin
      next_s.link_pulse = 1'b1;
    end
    if (next_s.state == ST_OFF) begin
      next_s.tx_oe = 1'b0;
    end else if (in10) begin
      next_s.tx_oe = s.lp_seen || s.ctrl_ign;
    end else begin
      next_s.tx_oe = 1'b1;
    end
    next_s.pol_inv = in10 ? sy_pol : 1'b0;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= REGS_RESET;
    end else begin
      s <= next_s;
    end
  end

  // MII speed is strap-only; no MDIO pins exist on these ports.
  assign mii0_speed_100 = s.mii0_100;
  assign mii1_speed_100 = s.mii1_100;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign tx_flp_word = s.adv;
  assign tx_flp_burst = s.flp_burst;
  assign tx_link_pulse = s.link_pulse;
  assign tx_stream_100 = s.stream_100;
  assign tx_manchester_en = s.manch;
  assign tp_transmit_pair_oe = s.tx_oe;
  assign rx_polarity_invert = s.pol_inv;
  assign attach_10 = s.att10;
  assign attach_100 = s.att100;
endmodule
`default_nettype wire

// *** testbench/tplc_port_asserts.sv ***
// Purpose: Concurrent checks on the port link controller outputs.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Attached to tplc_port by a bind in the bench top file.
`timescale 1ns/1ps
`default_nettype none
module tplc_port_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tp_receive_pair_idle,
  input wire logic tx_frame_active,
  input wire logic [15:0] tx_flp_word,
  input wire logic tx_flp_burst,
  input wire logic tx_link_pulse,
  input wire logic tx_stream_100,
  input wire logic tx_manchester_en,
  input wire logic tp_transmit_pair_oe,
  input wire logic attach_10,
  input wire logic attach_100,
  input wire logic mii0_speed_100,
  input wire logic mii1_speed_100
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] up_cnt;
  // Counts edges since reset release so strap capture has settled.
  always_ff @(posedge aclk) begin
    if (!aresetn) up_cnt <= 3'h0;
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  end
  a_adv_readonly: assert property ((tx_flp_word & 16'hdf5f) == 16'h0001)
    else $error("advertised word has a read-only bit changed");
  a_attach_single: assert property (!(attach_10 && attach_100))
    else $error("port attached to both repeaters");
  a_drive_oe: assert property ((tx_stream_100 || tx_manchester_en) |-> tp_transmit_pair_oe)
    else $error("transmit activity with pair undriven");
  a_burst_unlinked: assert property (tx_flp_burst |-> !attach_10 && !attach_100)
    else $error("burst sent while linked");
  a_burst_single: assert property (tx_flp_burst |=> !tx_flp_burst [*8])
    else $error("burst request longer than one cycle");
  a_stream_attach: assert property (attach_100 |-> tx_stream_100 && !tx_manchester_en)
    else $error("fast link without continuous stream");
  a_manch_frame: assert property (tx_manchester_en |-> $past(tx_frame_active) && !tx_stream_100)
    else $error("coded data outside a frame");
  a_pulse_single: assert property (tx_link_pulse |=> !tx_link_pulse [*8])
    else $error("link pulses too close");
  a_loss_detach: assert property (!tp_receive_pair_idle [*7] |-> !attach_100)
    else $error("fast link kept without idle");
  a_strap_hold: assert property (up_cnt == 3'h7 |-> $stable(mii0_speed_100) && $stable(mii1_speed_100))
    else $error("strapped speed changed after capture");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not cleared");
endmodule
`default_nettype wire

// *** testbench/tplc_partner.sv ***
// Purpose: Remote link partner on the receive pair.
// Assumes: Levels change right after rising edges of aclk.
// Notes: Released word lines show the inverse of the last word.
`timescale 1ns/1ps
`default_nettype none
module tplc_partner (
  input wire logic aclk,
  input wire logic pulses_on,
  input wire logic idle_on,
  input wire logic pol_on,
  output logic tp_receive_pair_link_pulse,
  output logic tp_receive_pair_idle,
  output logic tp_receive_pair_pol_rev,
  output logic tp_receive_pair_flp_stb,
  output logic [15:0] tp_receive_pair_flp_word
);
  int gap = 0;
  initial begin
    tp_receive_pair_link_pulse = 1'b0;
    tp_receive_pair_flp_stb = 1'b0;
    tp_receive_pair_flp_word = 16'h5a5a;
  end
  assign tp_receive_pair_idle = idle_on;
  assign tp_receive_pair_pol_rev = pol_on;
  // Pulses every 30 cycles, inside the accepted 25 to 50 cycle window.
  always @(posedge aclk) begin
    gap <= (gap == 29) ? 0 : gap + 1;
    tp_receive_pair_link_pulse <= pulses_on && gap < 6;
  end
  task automatic send_word(input logic [15:0] w);
    @(posedge aclk);
    tp_receive_pair_flp_word <= w;
    repeat (5) @(posedge aclk);
    tp_receive_pair_flp_stb <= 1'b1;
    repeat (6) @(posedge aclk);
    tp_receive_pair_flp_stb <= 1'b0;
    tp_receive_pair_flp_word <= ~w;
  endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the twisted-pair port link controller.
// Assumes: Link pulse counts shortened to 40, 25 and 50 cycles.
// Notes: Straps are flipped after reset to show that only a new reset samples them again.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tplc_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic pulses_on, idle_on, pol_on, strap_mii0_100, strap_mii1_100, tx_frame_active;
  logic tp_receive_pair_link_pulse, tp_receive_pair_idle, tp_receive_pair_pol_rev;
  logic tp_receive_pair_flp_stb, tx_flp_burst, tx_link_pulse, tx_stream_100;
  logic [15:0] tp_receive_pair_flp_word, tx_flp_word;
  logic tx_manchester_en, tp_transmit_pair_oe, rx_polarity_invert;
  logic attach_10, attach_100, mii0_speed_100, mii1_speed_100;
  int err_total, compares;
  tplc_port #(.LP_PERIOD(23'd40), .LP_MIN(23'd25), .LP_MAX(23'd50)) tplc_port_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tp_receive_pair_link_pulse, .tp_receive_pair_idle,
    .tp_receive_pair_pol_rev, .tp_receive_pair_flp_stb, .tp_receive_pair_flp_word,
    .strap_mii0_100, .strap_mii1_100, .tx_frame_active, .tx_flp_word, .tx_flp_burst,
    .tx_link_pulse, .tx_stream_100, .tx_manchester_en, .tp_transmit_pair_oe,
    .rx_polarity_invert, .attach_10, .attach_100, .mii0_speed_100, .mii1_speed_100);
  tplc_partner partner_i (.aclk, .pulses_on, .idle_on, .pol_on, .tp_receive_pair_link_pulse,
    .tp_receive_pair_idle, .tp_receive_pair_pol_rev, .tp_receive_pair_flp_stb,
    .tp_receive_pair_flp_word);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    chk("bvalid", 32'h1, 32'(s_axi_bvalid));
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    chk("rvalid", 32'h1, 32'(s_axi_rvalid));
    chk("rdata", exp, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask
  // Waits for one burst (sel 1) or one link pulse (sel 0), at most 100 cycles.
  task automatic wait_tx(input bit sel);
    int n;
    n = 0;
    while (!(sel ? tx_flp_burst : tx_link_pulse) && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk(sel ? "flp burst" : "link pulse", 32'h1, 32'(sel ? tx_flp_burst : tx_link_pulse));
  endtask
  task automatic set_mode(input logic [31:0] c);
    wr(ADDR_CTRL, c & 32'he, RESP_OKAY);
    cyc(2);
    chk("tx oe", 32'h0, 32'(tp_transmit_pair_oe));
    wr(ADDR_RPT_RESET, 32'h1, RESP_OKAY);
    wr(ADDR_CTRL, c, RESP_OKAY);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------------
  task automatic t_regs();
    rd(ADDR_CTRL, 32'h1, RESP_OKAY);
    rd(ADDR_STAT, 32'h240, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    chk("flp word", 32'h00a1, 32'(tx_flp_word));
    wr(ADDR_ADV, 32'hffff, RESP_OKAY);
    rd(ADDR_ADV, 32'h20a1, RESP_OKAY);
    chk("flp word", 32'h20a1, 32'(tx_flp_word));
    wr(ADDR_ADV, 32'h0, RESP_OKAY);
    rd(ADDR_ADV, 32'h1, RESP_OKAY);
    wr(ADDR_PARTNER, 32'hffff, RESP_OKAY);
    rd(ADDR_PARTNER, 32'h0, RESP_OKAY);
    $display("test regs done");
  endtask
  task automatic t_an();
    wait_tx(1'b1);
    partner_i.send_word(16'h00a1);
    cyc(12);
    rd(ADDR_STAT, 32'h250, RESP_OKAY);
    wr(ADDR_ADV, 32'h00a0, RESP_OKAY);
    wr(ADDR_RPT_RESET, 32'h1, RESP_OKAY);
    wait_tx(1'b1);
    fork
      partner_i.send_word(16'h0081);
      begin
        cyc(6);
        idle_on <= 1'b1;
      end
    join
    cyc(4);
    rd(ADDR_STAT, 32'h24b, RESP_OKAY);
    rd(ADDR_PARTNER, 32'h0081, RESP_OKAY);
    chk("stream", 32'h1, 32'(tx_stream_100));
    idle_on <= 1'b0;
    cyc(10);
    chk("attach 100", 32'h0, 32'(attach_100));
    wait_tx(1'b1);
    $display("test negotiation done");
  endtask
  task automatic t_ten();
    set_mode(32'h5);
    pol_on <= 1'b1;
    pulses_on <= 1'b1;
    cyc(80);
    rd(ADDR_STAT, 32'h265, RESP_OKAY);
    chk("pol invert", 32'h1, 32'(rx_polarity_invert));
    wait_tx(1'b0);
    tx_frame_active <= 1'b1;
    cyc(3);
    chk("manchester", 32'h1, 32'(tx_manchester_en));
    tx_frame_active <= 1'b0;
    cyc(3);
    chk("manchester", 32'h0, 32'(tx_manchester_en));
    pulses_on <= 1'b0;
    cyc(80);
    chk("tx oe", 32'h0, 32'(tp_transmit_pair_oe));
    chk("attach 10", 32'h0, 32'(attach_10));
    set_mode(32'hd);
    cyc(120);
    chk("tx oe", 32'h1, 32'(tp_transmit_pair_oe));
    wait_tx(1'b0);
    pol_on <= 1'b0;
    $display("test ten done");
  endtask
  task automatic t_hundred();
    strap_mii0_100 <= 1'b0;
    strap_mii1_100 <= 1'b1;
    set_mode(32'h3);
    idle_on <= 1'b1;
    cyc(10);
    chk("attach 100", 32'h1, 32'(attach_100));
    chk("mii0", 32'h1, 32'(mii0_speed_100));
    chk("mii1", 32'h0, 32'(mii1_speed_100));
    idle_on <= 1'b0;
    cyc(10);
    chk("attach 100", 32'h0, 32'(attach_100));
    aresetn <= 1'b0;
    cyc(3);
    aresetn <= 1'b1;
    cyc(6);
    rd(ADDR_CTRL, 32'h1, RESP_OKAY);
    chk("mii0", 32'h0, 32'(mii0_speed_100));
    chk("mii1", 32'h1, 32'(mii1_speed_100));
    $display("test hundred done");
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {pulses_on, idle_on, pol_on, tx_frame_active} = 4'h0;
    strap_mii0_100 = 1'b1;
    strap_mii1_100 = 1'b0;
    aresetn = 1'b0;
    err_total = 0;
    compares = 0;
    cyc(3);
    aresetn <= 1'b1;
    cyc(6);
    t_regs();
    t_an();
    t_ten();
    t_hundred();
    end_sim();
  end
  initial begin
    cyc(20000);
    err_total++;
    end_sim();
  end
endmodule
bind tplc_port tplc_port_asserts tplc_port_asserts_i (.aclk, .aresetn, .s_axi_rvalid,
  .s_axi_rready, .tp_receive_pair_idle, .tx_frame_active, .tx_flp_word, .tx_flp_burst,
  .tx_link_pulse, .tx_stream_100, .tx_manchester_en, .tp_transmit_pair_oe, .attach_10,
  .attach_100, .mii0_speed_100, .mii1_speed_100);
`default_nettype wire
